// >>> pkg/pia_pkg.sv
// constants, carriers and register map of the power-unit interrupt aggregator
// assumes one internal clock; pins arrive asynchronous, internal events synchronous
package pia_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ       = 125;
  localparam int unsigned HOLD_UNIT_US  = 1000;
  localparam int unsigned HOLD_UNIT_CYC = HOLD_UNIT_US * CLK_MHZ;
  localparam int unsigned ARM_STAGES    = 3;

  // ****************************************************************
  // register map (byte offsets on the internal register port)
  // ****************************************************************
  localparam logic [7:0] ADDR_STAT   = 8'h00;  // irq_group1_status .. irq_group4_status
  localparam logic [7:0] ADDR_MASK   = 8'h04;  // irq_source_mask, four groups
  localparam logic [7:0] ADDR_CTRL   = 8'h08;
  localparam logic [7:0] ADDR_RISE   = 8'h09;
  localparam logic [7:0] ADDR_FALL   = 8'h0A;
  localparam logic [7:0] RD_UNMAPPED = 8'hFF;

  localparam int unsigned CTRL_CLR_WRITE = 0;
  localparam int unsigned CTRL_POL_HIGH  = 1;
  localparam int unsigned CTRL_TICK_EN   = 2;
  localparam logic [2:0]  CTRL_RST       = 3'h0;
  localparam logic [7:0]  MASK_RST       = 8'h00;
  localparam logic [7:0]  RISE_RST       = 8'hFF;
  localparam logic [7:0]  FALL_RST       = 8'h00;

  // ****************************************************************
  // status bit positions
  // ****************************************************************
  localparam int unsigned B1_VSYS  = 6;
  localparam int unsigned B1_HOT   = 5;
  localparam int unsigned B1_PDN   = 4;
  localparam int unsigned B1_RPON  = 3;
  localparam int unsigned B1_LONG  = 2;
  localparam int unsigned B1_PBTN  = 1;
  localparam int unsigned B2_SHORT = 6;
  localparam int unsigned B2_RSTIN = 4;
  localparam int unsigned B2_WDOG  = 2;
  localparam int unsigned B2_TICK  = 1;
  localparam int unsigned B2_ALARM = 0;
  localparam int unsigned B3_USB   = 7;
  localparam int unsigned B3_DONE  = 2;
  localparam int unsigned B3_AUTO1 = 1;
  localparam int unsigned B3_AUTO0 = 0;

  // sources that wake only when unmasked, and those that always wake
  localparam logic [7:0] ONREQ_G2     = 8'h43;
  localparam logic [7:0] ONREQ_G3     = 8'h87;
  localparam logic [7:0] ONREQ_G4     = 8'hFF;
  localparam logic [7:0] ALWAYS_G1    = 8'h0A;

  // ****************************************************************
  // carriers
  // ****************************************************************
  localparam int unsigned PIN_N = 13;
  localparam int unsigned EV_N  = 9;
  localparam int unsigned P_PDN = 0;
  localparam int unsigned P_RPON = 1;
  localparam int unsigned P_PBTN = 2;
  localparam int unsigned P_RSTIN = 3;
  localparam int unsigned P_USB = 4;
  localparam int unsigned P_GPIO = 5;
  localparam int unsigned E_VSYS = 0;
  localparam int unsigned E_HOT = 1;
  localparam int unsigned E_SHORT = 2;
  localparam int unsigned E_WDOG = 3;
  localparam int unsigned E_TICK = 4;
  localparam int unsigned E_ALARM = 5;
  localparam int unsigned E_DONE = 6;
  localparam int unsigned E_AUTO1 = 7;
  localparam int unsigned E_AUTO0 = 8;

  typedef struct packed {
    logic [7:0] gpio;
    logic       usb_present;
    logic       reset_in;
    logic       power_button;
    logic       remote_power_on_pin;
    logic       power_down_pin;
  } pia_pins_type;

  typedef struct packed {
    logic converter_auto_ch0;
    logic converter_auto_ch1;
    logic converter_sw_done;
    logic alarm;
    logic tick;
    logic watchdog_expiry;
    logic out_short;
    logic overtemp_warning;
    logic supply_voltage_monitor;
  } pia_events_type;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       port_vs;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pia_req_type;

  typedef enum logic [1:0] {
    PWR_OFF    = 2'b00,
    PWR_SLEEP  = 2'b01,
    PWR_ACTIVE = 2'b10
  } pia_pwr_type;

endpackage : pia_pkg

// >>> rtl/pia_aggregator.sv
// interrupt aggregator: 23 sources into four status groups, one host line
// assumes the serial front end hands over decoded one-cycle register requests
//
// How it works
// - supply monitor, both edges, group1 bit6
// - overtemp both edges, bit5, not when off
// - power-down pin both edges, group1 bit4
// - remote-on pin falling while on, bit3, always wakes
// - button held past delay sets bit2
// - button falling while on, bit1, always wakes
// - output short rising, group2 bit6, wakes unmasked
// - reset-in pin rising sets group2 bit4
// - watchdog expiry rising sets group2 bit2
// - tick rising bit1, off by default, wakes
// - alarm rising sets group2 bit0, wakes
// - usb present both edges, group3 bit7
// - conversion done sets group3 bit2, wakes
// - auto channel1 threshold sets group3 bit1
// - auto channel0 threshold sets group3 bit0
// - gpio selected edges set group4 bits
// - strap picks two-wire or four-wire ports
// - voltage-scaling port cannot reach these registers in two-wire mode
// - unmasked pending bits ORed onto line
// - masked source never updates its bit
// - clear-on-read clears whole group
// - clear-on-write clears written ones
module pia_aggregator #(
  parameter int unsigned HOLD_UNIT_CYC = pia_pkg::HOLD_UNIT_CYC
) (
  input  wire logic                    mclk_i,
  input  wire logic                    srst_i,
  input  wire pia_pkg::pia_pins_type   pins_i,
  input  wire pia_pkg::pia_events_type events_i,
  input  wire pia_pkg::pia_pwr_type    pwr_state_i,
  input  wire logic                    two_wire_i,
  input  wire logic [7:0]              long_hold_delay_i,
  input  wire pia_pkg::pia_req_type    req_i,
  output logic [7:0]                   rd_data_o,
  output logic                         ack_o,
  output logic                         irq_line_o,
  output logic                         on_req_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [pia_pkg::PIN_N-1:0]      pin_raw;
  logic [pia_pkg::PIN_N-1:0]      meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;
  logic [pia_pkg::EV_N-1:0]       ev_raw, evprev_q, evprev_d;
  logic [pia_pkg::ARM_STAGES-1:0] arm_q, arm_d;
  logic [16:0]                    ms_cnt_q, ms_cnt_d;
  logic [7:0]                     hold_cnt_q, hold_cnt_d;
  logic                           hold_fired_q, hold_fired_d;
  logic [3:0][7:0]                status_q, status_d, mask_q, mask_d;
  logic [2:0]                     ctrl_q, ctrl_d;
  logic [7:0]                     rise_en_q, rise_en_d, fall_en_q, fall_en_d;
  logic [7:0]                     rdata_q, rdata_d;
  logic                           ack_q, ack_d, line_q, line_d, onreq_q, onreq_d;

  logic [pia_pkg::PIN_N-1:0] pin_rise, pin_fall;
  logic [pia_pkg::EV_N-1:0]  ev_rise, ev_fall;
  logic [3:0][7:0]           evt, set_v, clr_v;
  logic                      armed, on_state, ms_tick, hold_ev, acc_ok, pend_any;
  logic [3:0]                rd_hit, wr_hit;

  assign pin_raw  = pins_i;
  assign ev_raw   = events_i;
  assign armed    = arm_q[pia_pkg::ARM_STAGES-1];
  assign on_state = (pwr_state_i != pia_pkg::PWR_OFF);

  // ****************************************************************
  // edge detection
  // ****************************************************************
  // pin edges from second sync stage, event edges from the raw event inputs
  assign pin_rise = sync_q & ~prev_q;
  assign pin_fall = ~sync_q & prev_q;
  assign ev_rise  = ev_raw & ~evprev_q;
  assign ev_fall  = ~ev_raw & evprev_q;
  assign ms_tick  = (ms_cnt_q == 17'(HOLD_UNIT_CYC - 1));

  // ****************************************************************
  // source events per group
  // ****************************************************************
  always_comb begin
    evt = '0;
    evt[0][pia_pkg::B1_VSYS] = ev_rise[pia_pkg::E_VSYS] | ev_fall[pia_pkg::E_VSYS];
    evt[0][pia_pkg::B1_HOT] = (ev_rise[pia_pkg::E_HOT] | ev_fall[pia_pkg::E_HOT]) & on_state;
    evt[0][pia_pkg::B1_PDN] = pin_rise[pia_pkg::P_PDN] | pin_fall[pia_pkg::P_PDN];
    evt[0][pia_pkg::B1_RPON] = pin_fall[pia_pkg::P_RPON] & on_state;
    evt[0][pia_pkg::B1_LONG] = hold_ev;
    evt[0][pia_pkg::B1_PBTN] = pin_fall[pia_pkg::P_PBTN] & on_state;
    evt[1][pia_pkg::B2_SHORT] = ev_rise[pia_pkg::E_SHORT];
    evt[1][pia_pkg::B2_RSTIN] = pin_rise[pia_pkg::P_RSTIN];
    evt[1][pia_pkg::B2_WDOG] = ev_rise[pia_pkg::E_WDOG];
    // tick only when enabled, any power state
    evt[1][pia_pkg::B2_TICK] = ev_rise[pia_pkg::E_TICK] & ctrl_q[pia_pkg::CTRL_TICK_EN];
    evt[1][pia_pkg::B2_ALARM] = ev_rise[pia_pkg::E_ALARM];
    // usb present, stays live when off
    evt[2][pia_pkg::B3_USB] = pin_rise[pia_pkg::P_USB] | pin_fall[pia_pkg::P_USB];
    evt[2][pia_pkg::B3_DONE] = ev_rise[pia_pkg::E_DONE];
    evt[2][pia_pkg::B3_AUTO1] = ev_rise[pia_pkg::E_AUTO1];
    evt[2][pia_pkg::B3_AUTO0] = ev_rise[pia_pkg::E_AUTO0];
    evt[3] = (pin_rise[pia_pkg::P_GPIO +: 8] & rise_en_q) |
             (pin_fall[pia_pkg::P_GPIO +: 8] & fall_en_q);
    // pins settle through the synchroniser before edges count
    if (!armed) begin
      evt = '0;
    end
  end

  // ****************************************************************
  // register access decode
  // ****************************************************************
  always_comb begin
    // vs port blocked in two-wire mode
    acc_ok = req_i.valid && !(two_wire_i && req_i.port_vs);
    rd_hit = '0;
    wr_hit = '0;
    for (int g = 0; g < 4; g++) begin
      if (acc_ok && req_i.addr == pia_pkg::ADDR_STAT + 8'(g)) begin
        rd_hit[g] = !req_i.write;
        wr_hit[g] = req_i.write;
      end
    end
  end

  // ****************************************************************
  // status, masks and line
  // ****************************************************************
  always_comb begin
    pend_any = 1'h0;
    for (int g = 0; g < 4; g++) begin
      set_v[g] = evt[g] & ~mask_q[g];
      clr_v[g] = 8'h00;
      if (rd_hit[g] && !ctrl_q[pia_pkg::CTRL_CLR_WRITE]) begin
        clr_v[g] = 8'hFF;
      end
      if (wr_hit[g] && ctrl_q[pia_pkg::CTRL_CLR_WRITE]) begin
        clr_v[g] = req_i.wdata;
      end
      status_d[g] = (status_q[g] & ~clr_v[g]) | set_v[g];
      pend_any    = pend_any | (|(status_q[g] & ~mask_q[g]));
    end
    line_d  = ctrl_q[pia_pkg::CTRL_POL_HIGH] ? pend_any : !pend_any;
    onreq_d = (|(status_q[0] & pia_pkg::ALWAYS_G1)) |
              (|(status_q[1] & ~mask_q[1] & pia_pkg::ONREQ_G2)) |
              (|(status_q[2] & ~mask_q[2] & pia_pkg::ONREQ_G3)) |
              (|(status_q[3] & ~mask_q[3] & pia_pkg::ONREQ_G4));
  end

  // ****************************************************************
  // configuration registers and read path
  // ****************************************************************
  always_comb begin
    mask_d    = mask_q;
    ctrl_d    = ctrl_q;
    rise_en_d = rise_en_q;
    fall_en_d = fall_en_q;
    rdata_d   = rdata_q;
    ack_d     = req_i.valid;
    if (acc_ok && req_i.write) begin
      if (req_i.addr >= pia_pkg::ADDR_MASK && req_i.addr < pia_pkg::ADDR_CTRL) begin
        mask_d[req_i.addr[1:0]] = req_i.wdata;
      end else if (req_i.addr == pia_pkg::ADDR_CTRL) begin
        ctrl_d = req_i.wdata[2:0];
      end else if (req_i.addr == pia_pkg::ADDR_RISE) begin
        rise_en_d = req_i.wdata;
      end else if (req_i.addr == pia_pkg::ADDR_FALL) begin
        fall_en_d = req_i.wdata;
      end
    end
    if (req_i.valid && !req_i.write) begin
      if (!acc_ok) begin
        rdata_d = pia_pkg::RD_UNMAPPED;
      end else if (req_i.addr < pia_pkg::ADDR_MASK) begin
        rdata_d = status_q[req_i.addr[1:0]];
      end else if (req_i.addr < pia_pkg::ADDR_CTRL) begin
        rdata_d = mask_q[req_i.addr[1:0]];
      end else if (req_i.addr == pia_pkg::ADDR_CTRL) begin
        rdata_d = {5'h00, ctrl_q};
      end else if (req_i.addr == pia_pkg::ADDR_RISE) begin
        rdata_d = rise_en_q;
      end else if (req_i.addr == pia_pkg::ADDR_FALL) begin
        rdata_d = fall_en_q;
      end else begin
        rdata_d = pia_pkg::RD_UNMAPPED;
      end
    end
  end

  // ****************************************************************
  // synchroniser, millisecond divider, long hold
  // ****************************************************************
  always_comb begin
    meta_d       = pin_raw;
    sync_d       = meta_q;
    prev_d       = sync_q;
    evprev_d     = ev_raw;
    arm_d        = {arm_q[pia_pkg::ARM_STAGES-2:0], 1'h1};
    ms_cnt_d     = ms_tick ? 17'h00000 : ms_cnt_q + 17'h00001;
    hold_cnt_d   = hold_cnt_q;
    hold_fired_d = hold_fired_q;
    hold_ev      = 1'h0;
    // count whole units while held low
    if (sync_q[pia_pkg::P_PBTN]) begin
      hold_cnt_d   = 8'h00;
      hold_fired_d = 1'h0;
    end else if (ms_tick && !hold_fired_q) begin
      if (hold_cnt_q == long_hold_delay_i) begin
        hold_ev      = 1'h1;
        hold_fired_d = 1'h1;
      end else begin
        hold_cnt_d = hold_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      meta_q       <= '0;
      sync_q       <= '0;
      prev_q       <= '0;
      evprev_q     <= '0;
      arm_q        <= '0;
      ms_cnt_q     <= 17'h00000;
      hold_cnt_q   <= 8'h00;
      hold_fired_q <= 1'h0;
      status_q     <= '0;
      mask_q       <= {4{pia_pkg::MASK_RST}};
      ctrl_q       <= pia_pkg::CTRL_RST;
      rise_en_q    <= pia_pkg::RISE_RST;
      fall_en_q    <= pia_pkg::FALL_RST;
      rdata_q      <= 8'h00;
      ack_q        <= 1'h0;
      line_q       <= 1'h1;
      onreq_q      <= 1'h0;
    end else begin
      meta_q       <= meta_d;
      sync_q       <= sync_d;
      prev_q       <= prev_d;
      evprev_q     <= evprev_d;
      arm_q        <= arm_d;
      ms_cnt_q     <= ms_cnt_d;
      hold_cnt_q   <= hold_cnt_d;
      hold_fired_q <= hold_fired_d;
      status_q     <= status_d;
      mask_q       <= mask_d;
      ctrl_q       <= ctrl_d;
      rise_en_q    <= rise_en_d;
      fall_en_q    <= fall_en_d;
      rdata_q      <= rdata_d;
      ack_q        <= ack_d;
      line_q       <= line_d;
      onreq_q      <= onreq_d;
    end
  end

  // host clears by repeated passes over the groups
  assign rd_data_o  = rdata_q;
  assign ack_o      = ack_q;
  assign irq_line_o = line_q;
  assign on_req_o   = onreq_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  sequence s_press;
    armed && on_state && !mask_q[0][pia_pkg::B1_PBTN] && pin_fall[pia_pkg::P_PBTN];
  endsequence
  sequence s_flag_then_wake;
    status_q[0][pia_pkg::B1_PBTN] ##1 on_req_o;
  endsequence

  a_press_wakes: assert property (s_press |=> s_flag_then_wake)
    else $error("button press did not flag and wake");
  a_vsys_both: assert property (armed && !mask_q[0][pia_pkg::B1_VSYS] &&
      (ev_raw[pia_pkg::E_VSYS] != evprev_q[pia_pkg::E_VSYS]) |=> status_q[0][pia_pkg::B1_VSYS])
    else $error("supply crossing not flagged");
  a_hot_not_off: assert property ($rose(status_q[0][pia_pkg::B1_HOT]) |->
      $past(pwr_state_i) != pia_pkg::PWR_OFF)
    else $error("overtemp flagged while off");
  a_rpon_not_off: assert property ($rose(status_q[0][pia_pkg::B1_RPON]) |->
      $past(pwr_state_i) != pia_pkg::PWR_OFF)
    else $error("remote-on flagged while off");
  a_hold_delay: assert property ($rose(status_q[0][pia_pkg::B1_LONG]) |->
      $past(hold_cnt_q) == $past(long_hold_delay_i) && !$past(sync_q[pia_pkg::P_PBTN]))
    else $error("long hold flagged at wrong count");
  a_tick_gated: assert property ($rose(status_q[1][pia_pkg::B2_TICK]) |->
      $past(ctrl_q[pia_pkg::CTRL_TICK_EN]))
    else $error("tick flagged while disabled");
  a_mask_blocks: assert property ((~$past(status_q) & $past(mask_q) & status_q) == '0)
    else $error("masked source set its bit");
  a_set_sticky: assert property (|set_v |=> (status_q & $past(set_v)) == $past(set_v))
    else $error("event lost against clear");
  a_read_clear: assert property (rd_hit[0] && !ctrl_q[pia_pkg::CTRL_CLR_WRITE] &&
      set_v[0] == 8'h00 |=> status_q[0] == 8'h00)
    else $error("read did not clear group");
  a_write_clear: assert property (wr_hit[1] && ctrl_q[pia_pkg::CTRL_CLR_WRITE] &&
      set_v[1] == 8'h00 |=> status_q[1] == ($past(status_q[1]) & ~$past(req_i.wdata)))
    else $error("write clear wrong bits");
  a_vs_blocked: assert property (req_i.valid && !req_i.write && two_wire_i &&
      req_i.port_vs |=> rd_data_o == pia_pkg::RD_UNMAPPED &&
      status_q == ($past(status_q) | $past(set_v)))
    else $error("voltage-scaling port reached status");
  a_line_level: assert property (irq_line_o ==
      ($past(ctrl_q[pia_pkg::CTRL_POL_HIGH]) ? $past(pend_any) : !$past(pend_any)))
    else $error("interrupt line wrong level");

endmodule : pia_aggregator

// >>> dv/pia_host_model.sv
// host-side model: register-port master that also services the interrupt line
// assumes clear-on-read mode and the default low line polarity while servicing
module pia_host_model (
  input  wire logic               mclk_i,
  input  wire logic               svc_en_i,
  input  wire logic               irq_line_i,
  input  wire logic [7:0]         rd_data_i,
  input  wire logic               ack_i,
  output var  pia_pkg::pia_req_type req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] seen;
  logic       seen_ack;

  initial req_o = '0;

  // one-cycle request pulse; fields scrambled after release so stale values never look valid
  task automatic xfer(input logic w, input logic vs, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic ak);
    @(negedge mclk_i);
    req_o = '{1'b1, w, vs, a, d};
    @(negedge mclk_i);
    ak = ack_i;
    q = rd_data_i;
    req_o = '{1'b0, ~w, ~vs, ~a, ~d};
  endtask

  always begin
    @(negedge mclk_i);
    if (svc_en_i && irq_line_i === 1'b0) begin
      for (int g = 0; g < 4; g++) xfer(1'b0, 1'b0, 8'(g), 8'h00, seen, seen_ack);
    end
  end
endmodule // pia_host_model

// >>> dv/tb.sv
// self-checking bench of the interrupt aggregator
// assumes pia_host_model drives the register port; hold unit shortened to 4 cycles
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic       pin;
    logic [3:0] pos;
    logic [1:0] grp;
    logic [2:0] bitn;
    logic       fall;
    logic       both;
    logic       wake;
    logic       act;
  } pia_src_type;

  logic                    mclk = 1'b0;
  logic                    srst = 1'b1;
  pia_pkg::pia_pins_type   pins = 13'h0006;
  pia_pkg::pia_events_type evts = '0;
  pia_pkg::pia_pwr_type    pwr  = pia_pkg::PWR_ACTIVE;
  logic                    two_wire = 1'b0;
  logic                    svc = 1'b0;
  logic [7:0]              hold = 8'h0F;
  logic [7:0]              lfsr = 8'h3A;
  pia_pkg::pia_req_type    req;
  logic [7:0]              rdat, q, r, f, v;
  logic                    ack, irq, onr, ak, ex;
  int                      num_errors = 0;
  int                      total_checks = 0;
  pia_src_type             s;

  always #4 mclk = ~mclk;

  pia_aggregator #(.HOLD_UNIT_CYC(4)) pia_aggregator_i (
    .mclk_i(mclk), .srst_i(srst), .pins_i(pins), .events_i(evts), .pwr_state_i(pwr),
    .two_wire_i(two_wire), .long_hold_delay_i(hold), .req_i(req), .rd_data_o(rdat),
    .ack_o(ack), .irq_line_o(irq), .on_req_o(onr));

  pia_host_model pia_host_model_i (
    .mclk_i(mclk), .svc_en_i(svc), .irq_line_i(irq), .rd_data_i(rdat), .ack_i(ack),
    .req_o(req));

  // ****************************************************************
  // expectations and helpers
  // ****************************************************************
  function automatic logic [7:0] next_rand(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // pin/event position, group, bit, flags fall, both, wake, only-when-on
  function automatic pia_src_type src(input int i);
    case (i)
      0:  return {1'b0, 4'h0, 2'h0, 3'h6, 4'b0100};
      1:  return {1'b0, 4'h1, 2'h0, 3'h5, 4'b0101};
      2:  return {1'b1, 4'h0, 2'h0, 3'h4, 4'b0100};
      3:  return {1'b1, 4'h1, 2'h0, 3'h3, 4'b1011};
      4:  return {1'b1, 4'h2, 2'h0, 3'h1, 4'b1011};
      5:  return {1'b0, 4'h2, 2'h1, 3'h6, 4'b0010};
      6:  return {1'b1, 4'h3, 2'h1, 3'h4, 4'b0000};
      7:  return {1'b0, 4'h3, 2'h1, 3'h2, 4'b0000};
      8:  return {1'b0, 4'h4, 2'h1, 3'h1, 4'b0010};
      9:  return {1'b0, 4'h5, 2'h1, 3'h0, 4'b0010};
      10: return {1'b1, 4'h4, 2'h2, 3'h7, 4'b0110};
      11: return {1'b0, 4'h6, 2'h2, 3'h2, 4'b0010};
      12: return {1'b0, 4'h7, 2'h2, 3'h1, 4'b0010};
      13: return {1'b0, 4'h8, 2'h2, 3'h0, 4'b0010};
      default: return {1'b1, 4'(i - 9), 2'h3, 3'(i - 14), 4'b0010};
    endcase
  endfunction

  task automatic chk_data(input logic [7:0] g, input logic [7:0] e, input string w);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, w, g, e);
    end
  endtask

  task automatic chk_flag(input logic g, input logic e, input string w);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: %s got %b want %b", $time, w, g, e);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string w);
    logic [7:0] d;
    logic       k;
    pia_host_model_i.xfer(1'b0, 1'b0, a, 8'h00, d, k);
    chk_flag(k, 1'b1, w);
    chk_data(d, e, w);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic       k;
    pia_host_model_i.xfer(1'b1, 1'b0, a, d, x, k);
    chk_flag(k, 1'b1, "write ack");
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic poke(input pia_src_type t, input logic lv);
    @(negedge mclk);
    if (t.pin) pins[t.pos] = lv;
    else evts[t.pos] = lv;
  endtask

  task automatic endtest(input string n);
    $display("test %s done at %0t", n, $time);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("unexpected at %0t: run timed out", $time);
    tally_and_finish();
  end

  initial begin
    cyc(5);
    srst = 1'b0;
    cyc(4);
    for (int a = 4; a < 11; a++) rd(8'(a), (a == 9) ? 8'hFF : 8'h00, "reset value");
    rd(8'h3C, 8'hFF, "unmapped");
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h07, "ctrl bits");
    chk_flag(irq, 1'b0, "high polarity idle");
    wr(8'h08, 8'h00);
    cyc(2);
    chk_flag(irq, 1'b1, "low polarity idle");
    two_wire = 1'b1;
    pia_host_model_i.xfer(1'b1, 1'b1, 8'h04, 8'hFF, q, ak);
    pia_host_model_i.xfer(1'b0, 1'b1, 8'h0A, 8'h00, q, ak);
    chk_data(q, 8'hFF, "scaling port read");
    rd(8'h04, 8'h00, "scaling port write");
    two_wire = 1'b0;
    pia_host_model_i.xfer(1'b0, 1'b1, 8'h0A, 8'h00, q, ak);
    chk_data(q, 8'h00, "four-wire read");
    endtest("registers");
    // active with tick left off, then off and sleep with tick enabled
    for (int p = 0; p < 3; p++) begin
      pwr = (p == 1) ? pia_pkg::PWR_OFF : (p == 2) ? pia_pkg::PWR_SLEEP : pia_pkg::PWR_ACTIVE;
      wr(8'h08, p ? 8'h04 : 8'h00);
      for (int i = 0; i < 22; i++) begin
        s = src(i);
        ex = !((p == 1 && s.act) || (p == 0 && i == 8));
        poke(s, !s.fall);
        cyc(6);
        chk_flag(irq, !ex, "line");
        chk_flag(onr, ex & s.wake, "wake request");
        rd({6'h00, s.grp}, 8'(ex) << s.bitn, "active edge");
        poke(s, s.fall);
        cyc(6);
        rd({6'h00, s.grp}, 8'(ex & s.both) << s.bitn, "return edge");
      end
    end
    endtest("sources");
    pwr = pia_pkg::PWR_ACTIVE;
    wr(8'h08, 8'h00);
    hold = {6'h00, lfsr[1:0]};
    poke(src(4), 1'b0);
    cyc((hold + 3) * 4 + 8);
    rd(8'h00, 8'h06, "long hold");
    cyc(40);
    rd(8'h00, 8'h00, "once per press");
    poke(src(4), 1'b1);
    for (int k = 0; k < 4; k++) begin
      lfsr = next_rand(lfsr);
      r = lfsr;
      lfsr = next_rand(lfsr);
      f = lfsr;
      lfsr = next_rand(lfsr);
      v = lfsr;
      wr(8'h09, r);
      wr(8'h0A, f);
      @(negedge mclk);
      pins.gpio = v;
      cyc(6);
      rd(8'h03, v & r, "gpio rise");
      @(negedge mclk);
      pins.gpio = 8'h00;
      cyc(6);
      rd(8'h03, v & f, "gpio fall");
    end
    endtest("edges");
    wr(8'h05, 8'h40);
    poke(src(5), 1'b1);
    cyc(6);
    chk_flag(irq, 1'b1, "masked line");
    chk_flag(onr, 1'b0, "masked wake");
    wr(8'h05, 8'h00);
    rd(8'h01, 8'h00, "event lost");
    poke(src(5), 1'b0);
    wr(8'h08, 8'h01);
    poke(src(9), 1'b1);
    poke(src(7), 1'b1);
    cyc(6);
    rd(8'h01, 8'h05, "sticky");
    rd(8'h01, 8'h05, "read keeps");
    wr(8'h01, 8'h01);
    rd(8'h01, 8'h04, "one bit cleared");
    chk_flag(irq, 1'b0, "still pending");
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h00, "group cleared");
    chk_flag(irq, 1'b1, "line released");
    poke(src(9), 1'b0);
    poke(src(7), 1'b0);
    endtest("clearing");
    wr(8'h08, 8'h00);
    svc = 1'b1;
    poke(src(0), 1'b1);
    cyc(5);
    poke(src(11), 1'b1);
    poke(src(0), 1'b0);
    poke(src(11), 1'b0);
    cyc(3);
    for (int w = 0; w < 80 && irq !== 1'b1; w++) cyc(1);
    svc = 1'b0;
    cyc(12);
    chk_flag(irq, 1'b1, "serviced");
    for (int g = 0; g < 4; g++) rd(8'(g), 8'h00, "all clear");
    endtest("service");
    tally_and_finish();
  end
endmodule // tb
